// ==== cppcr_pkg.sv ====
package cppcr_pkg;

    localparam int          ADDR_W         = 15;
    localparam int          DATA_W         = 8;
    localparam int          FRAME_BITS     = 24;

    // Register offsets
    localparam logic [14:0] OFS_MODE_SEL_1 = 15'h0037;
    localparam logic [14:0] OFS_TS_CTRL    = 15'h003B;
    localparam logic [14:0] OFS_REFO_CTRL  = 15'h003C;
    localparam logic [14:0] OFS_DIV_A      = 15'h003D;
    localparam logic [14:0] OFS_DIV_B      = 15'h003E;

    // Reset values
    localparam logic [7:0]  RST_MODE_SEL_1 = 8'h4B;
    localparam logic [7:0]  RST_TS_CTRL    = 8'h00;
    localparam logic [7:0]  RST_REFO_CTRL  = 8'h01;
    localparam logic [7:0]  RST_DIV_A      = 8'h00;
    localparam logic [7:0]  RST_DIV_B      = 8'h20;

    // Mode codes
    localparam logic [7:0]  MODE_LOW_POWER = 8'h46;
    localparam logic [7:0]  MODE_HIGH_PERF = 8'h4B;

    // Field positions
    localparam int          TS_RECV_BIT    = 0;
    localparam int          TS_PECL_BIT    = 1;
    localparam int          REFO_EN_BIT    = 0;
    localparam int          DIV_V_LSB      = 0;
    localparam int          DIV_P_LSB      = 2;
    localparam int          DIV_N_LSB      = 0;

    // First divider: 5, 4, 3; zero marks a reserved code
    function automatic logic [2:0] cppcr_v_ratio(input logic [1:0] code);
        case (code)
            2'h0:    return 3'h5;
            2'h1:    return 3'h4;
            2'h2:    return 3'h3;
            default: return 3'h0;
        endcase
    endfunction : cppcr_v_ratio

    // Second divider: 1, 2, 4; zero marks a reserved code
    function automatic logic [2:0] cppcr_p_ratio(input logic [1:0] code);
        case (code)
            2'h0:    return 3'h1;
            2'h1:    return 3'h2;
            2'h2:    return 3'h4;
            default: return 3'h0;
        endcase
    endfunction : cppcr_p_ratio

endpackage : cppcr_pkg

// ==== cppcr_bus_if.sv ====
`timescale 1ns/1ps
interface cppcr_bus_if;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;

    modport ctrl (output addr, output wdata, output wr, output rd, input rdata);
    modport regs (input addr, input wdata, input wr, input rd, output rdata);
endinterface : cppcr_bus_if

// ==== cppcr_spi_port.sv ====
`timescale 1ns/1ps
module cppcr_spi_port
    import cppcr_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst,
    // Serial control pins
    input  wire logic  sclk,
    input  wire logic  scs_n,
    input  wire logic  sdi,
    output logic       sdo,
    output logic       sdo_oe,
    // Register side
    cppcr_bus_if.ctrl  bus
);
    logic        sclk_q,  next_sclk_q;
    logic [4:0]  cnt,     next_cnt;
    logic [23:0] shin,    next_shin;
    logic [7:0]  outsh,   next_outsh;
    logic        rw,      next_rw;
    logic        load,    next_load;
    logic        sdo_r,   next_sdo;
    logic        wr,      next_wr;
    logic        rd,      next_rd;
    logic [14:0] addr,    next_addr;
    logic [7:0]  wdata,   next_wdata;
    logic        rise;
    logic        fall;

    assign rise      = sclk & ~sclk_q & ~scs_n;
    assign fall      = ~sclk & sclk_q & ~scs_n;
    assign sdo       = sdo_r;
    assign sdo_oe    = ~scs_n & rw & (cnt >= 5'h10);
    assign bus.addr  = addr;
    assign bus.wdata = wdata;
    assign bus.wr    = wr;
    assign bus.rd    = rd;

    // SCLK is sampled by the system clock, so it must run well below 5 MHz
    always_comb begin
        next_sclk_q = sclk;
        next_cnt    = cnt;
        next_shin   = shin;
        next_outsh  = outsh;
        next_rw     = rw;
        next_load   = rd;
        next_sdo    = sdo_r;
        next_wr     = 1'b0;
        next_rd     = 1'b0;
        next_addr   = addr;
        next_wdata  = wdata;
        if (scs_n) begin
            next_cnt = 5'h0;
            next_rw  = 1'b0;
        end else if (rise) begin
            next_shin = {shin[22:0], sdi};
            if (cnt != 5'(FRAME_BITS))
                next_cnt = 5'(cnt + 5'h1);
            if (cnt == 5'h0)
                next_rw = sdi;
            if (cnt == 5'hF) begin
                next_addr = {shin[13:0], sdi};
                next_rd   = rw;
            end
            if (cnt == 5'h17) begin
                next_wdata = {shin[6:0], sdi};
                next_wr    = ~rw;
            end
        end
        if (load) begin
            next_outsh = bus.rdata;
        end else if (fall && rw && cnt >= 5'h10) begin
            next_sdo   = outsh[7];
            next_outsh = {outsh[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_q <= 1'b0;
            cnt    <= 5'h0;
            shin   <= 24'h000000;
            outsh  <= 8'h00;
            rw     <= 1'b0;
            load   <= 1'b0;
            sdo_r  <= 1'b0;
            wr     <= 1'b0;
            rd     <= 1'b0;
            addr   <= 15'h0000;
            wdata  <= 8'h00;
        end else begin
            sclk_q <= next_sclk_q;
            cnt    <= next_cnt;
            shin   <= next_shin;
            outsh  <= next_outsh;
            rw     <= next_rw;
            load   <= next_load;
            sdo_r  <= next_sdo;
            wr     <= next_wr;
            rd     <= next_rd;
            addr   <= next_addr;
            wdata  <= next_wdata;
        end
    end
endmodule : cppcr_spi_port

// ==== cppcr_config_regs.sv ====
`timescale 1ns/1ps
module cppcr_config_regs
    import cppcr_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst,
    // Serial control port
    input  wire logic  sclk,
    input  wire logic  scs_n,
    input  wire logic  sdi,
    output logic       sdo,
    output logic       sdo_oe,
    // Device inputs
    input  wire logic  pll_enable,
    input  wire logic  timestamp_input,
    // Operating mode
    output logic [7:0] operating_mode_code,
    output logic       low_power_mode,
    output logic       high_perf_mode,
    output logic       mode_code_reserved,
    // Timestamp receiver
    output logic       timestamp_receiver_enable,
    output logic       timestamp_pecl_mode,
    output logic       timestamp_received,
    // Reference clock output
    output logic       reference_clock_output,
    // Feedback dividers
    output logic [2:0] div_v_ratio,
    output logic [2:0] div_p_ratio,
    output logic [5:0] div_n_ratio,
    output logic       div_code_reserved
);
    cppcr_bus_if bus ();

    cppcr_spi_port u_spi (
        .clock  (clock),
        .rst    (rst),
        .sclk   (sclk),
        .scs_n  (scs_n),
        .sdi    (sdi),
        .sdo    (sdo),
        .sdo_oe (sdo_oe),
        .bus    (bus.ctrl)
    );

    logic [7:0] mode_reg, next_mode_reg;
    logic [7:0] ts_reg,   next_ts_reg;
    logic [7:0] refo_reg, next_refo_reg;
    logic [7:0] diva_reg, next_diva_reg;
    logic [7:0] divb_reg, next_divb_reg;

    // Reserved bits are stored as written so software reads back what it wrote
    always_comb begin
        next_mode_reg = mode_reg;
        next_ts_reg   = ts_reg;
        next_refo_reg = refo_reg;
        next_diva_reg = diva_reg;
        next_divb_reg = divb_reg;
        if (bus.wr) begin
            case (bus.addr)
                OFS_MODE_SEL_1: next_mode_reg = bus.wdata;
                OFS_TS_CTRL:    next_ts_reg   = bus.wdata;
                OFS_REFO_CTRL:  next_refo_reg = bus.wdata;
                OFS_DIV_A:      next_diva_reg = bus.wdata;
                OFS_DIV_B:      next_divb_reg = bus.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_reg <= RST_MODE_SEL_1;
            ts_reg   <= RST_TS_CTRL;
            refo_reg <= RST_REFO_CTRL;
            diva_reg <= RST_DIV_A;
            divb_reg <= RST_DIV_B;
        end else begin
            mode_reg <= next_mode_reg;
            ts_reg   <= next_ts_reg;
            refo_reg <= next_refo_reg;
            diva_reg <= next_diva_reg;
            divb_reg <= next_divb_reg;
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        case (bus.addr)
            OFS_MODE_SEL_1: bus.rdata = mode_reg;
            OFS_TS_CTRL:    bus.rdata = ts_reg;
            OFS_REFO_CTRL:  bus.rdata = refo_reg;
            OFS_DIV_A:      bus.rdata = diva_reg;
            OFS_DIV_B:      bus.rdata = divb_reg;
            default:        bus.rdata = 8'h00;
        endcase
    end

    // Decoded outputs, one cycle behind the registers
    logic       next_low, next_high, next_mres;
    logic       next_ts_en, next_ts_pecl, next_ts_rx, next_refo;
    logic [2:0] next_v, next_p;
    logic [5:0] next_n;
    logic       next_dres;

    always_comb begin
        next_low     = (mode_reg == MODE_LOW_POWER);
        next_high    = (mode_reg == MODE_HIGH_PERF);
        next_mres    = !next_low && !next_high;
        next_ts_en   = ts_reg[TS_RECV_BIT];
        next_ts_pecl = ts_reg[TS_PECL_BIT];
        next_ts_rx   = ts_reg[TS_RECV_BIT] & timestamp_input;
        next_refo    = refo_reg[REFO_EN_BIT] & pll_enable;
        next_v       = cppcr_v_ratio(diva_reg[DIV_V_LSB +: 2]);
        next_p       = cppcr_p_ratio(diva_reg[DIV_P_LSB +: 2]);
        next_n       = divb_reg[DIV_N_LSB +: 6];
        // A zero N value is unsupported, so it is flagged with the reserved codes
        next_dres    = (next_v == 3'h0) || (next_p == 3'h0) || (next_n == 6'h00);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            operating_mode_code       <= RST_MODE_SEL_1;
            low_power_mode            <= 1'b0;
            high_perf_mode            <= 1'b1;
            mode_code_reserved        <= 1'b0;
            timestamp_receiver_enable <= 1'b0;
            timestamp_pecl_mode       <= 1'b0;
            timestamp_received        <= 1'b0;
            reference_clock_output    <= 1'b0;
            div_v_ratio               <= 3'h5;
            div_p_ratio               <= 3'h1;
            div_n_ratio               <= RST_DIV_B[5:0];
            div_code_reserved         <= 1'b0;
        end else begin
            operating_mode_code       <= mode_reg;
            low_power_mode            <= next_low;
            high_perf_mode            <= next_high;
            mode_code_reserved        <= next_mres;
            timestamp_receiver_enable <= next_ts_en;
            timestamp_pecl_mode       <= next_ts_pecl;
            timestamp_received        <= next_ts_rx;
            reference_clock_output    <= next_refo;
            div_v_ratio               <= next_v;
            div_p_ratio               <= next_p;
            div_n_ratio               <= next_n;
            div_code_reserved         <= next_dres;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Outputs are registered, so each check looks one edge after its cause
    a_mode_low_decode: assert property (
        (mode_reg == MODE_LOW_POWER)
        |=> low_power_mode && !high_perf_mode && !mode_code_reserved)
        else $error("low power code not decoded");
    a_mode_high_decode: assert property (
        (mode_reg == MODE_HIGH_PERF)
        |=> high_perf_mode && !low_power_mode && !mode_code_reserved)
        else $error("high performance code not decoded");
    a_mode_other_reserved: assert property (
        (mode_reg != MODE_LOW_POWER && mode_reg != MODE_HIGH_PERF)
        |=> mode_code_reserved && !low_power_mode && !high_perf_mode)
        else $error("reserved mode code not flagged");
    a_mode_code_copy: assert property (
        ##1 operating_mode_code == $past(mode_reg))
        else $error("mode code output differs from register");
    a_ts_input_ignored: assert property (
        !ts_reg[TS_RECV_BIT]
        |=> !timestamp_received)
        else $error("timestamp seen while receiver off");
    a_ts_input_seen: assert property (
        (ts_reg[TS_RECV_BIT] && timestamp_input)
        |=> timestamp_received)
        else $error("timestamp missed while receiver on");
    a_ts_pecl_select: assert property (
        ##1 timestamp_pecl_mode == $past(ts_reg[TS_PECL_BIT]))
        else $error("pecl mode does not follow control bit");
    a_refout_and_gate: assert property (
        ##1 reference_clock_output
            == ($past(refo_reg[REFO_EN_BIT]) && $past(pll_enable)))
        else $error("reference output not the AND of its controls");
    a_refout_reset_on: assert property (
        $past(rst) |-> refo_reg == RST_REFO_CTRL
        ##1 reference_clock_output == $past(pll_enable))
        else $error("reference output enable not set after reset");
    a_div_p_ratio: assert property (
        (diva_reg[DIV_P_LSB +: 2] == 2'h2)
        |=> div_p_ratio == 3'h4)
        else $error("second divider code 2 not divide by 4");
    a_div_v_ratio: assert property (
        (diva_reg[DIV_V_LSB +: 2] == 2'h0)
        |=> div_v_ratio == 3'h5)
        else $error("first divider code 0 not divide by 5");
    a_div_reserved_flag: assert property (
        (diva_reg[DIV_V_LSB +: 2] == 2'h3 || diva_reg[DIV_P_LSB +: 2] == 2'h3)
        |=> div_code_reserved && (div_v_ratio == 3'h0 || div_p_ratio == 3'h0))
        else $error("reserved divider code not flagged");
    a_div_n_ratio: assert property (
        ##1 div_n_ratio == $past(divb_reg[DIV_N_LSB +: 6]))
        else $error("third divider ratio differs from field");
    a_div_n_zero: assert property (
        (divb_reg[DIV_N_LSB +: 6] == 6'h00)
        |=> div_code_reserved)
        else $error("unsupported third divider value not flagged");
    a_div_n_reset: assert property (
        $past(rst)
        |-> divb_reg == RST_DIV_B && div_n_ratio == RST_DIV_B[DIV_N_LSB +: 6])
        else $error("third divider not 32 after reset");
    a_readback_value: assert property (
        (bus.wr && bus.addr == OFS_DIV_B) ##1 (bus.addr == OFS_DIV_B)
        |-> bus.rdata == $past(bus.wdata))
        else $error("written value not read back");

    // Scenarios a full run is expected to reach
    c_low_power_mode: cover property (low_power_mode);
    c_mode_reserved: cover property (mode_code_reserved);
    c_refout_running: cover property (reference_clock_output);
    c_ts_received: cover property (timestamp_received && timestamp_pecl_mode);
    c_div_reserved: cover property (div_code_reserved);
endmodule : cppcr_config_regs

// ==== cppcr_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module testbench
    import cppcr_pkg::*;
;
    // Clock and reset
    logic       clock;
    logic       rst;
    // Serial control port
    logic       sclk;
    logic       scs_n;
    logic       sdi;
    logic       sdo;
    logic       sdo_oe;
    // Device inputs
    logic       pll_enable;
    logic       timestamp_input;
    // Decoded outputs
    logic [7:0] operating_mode_code;
    logic       low_power_mode;
    logic       high_perf_mode;
    logic       mode_code_reserved;
    logic       timestamp_receiver_enable;
    logic       timestamp_pecl_mode;
    logic       timestamp_received;
    logic       reference_clock_output;
    logic [2:0] div_v_ratio;
    logic [2:0] div_p_ratio;
    logic [5:0] div_n_ratio;
    logic       div_code_reserved;
    // Bench state
    int         fail_count;
    int         checked;
    logic [7:0] rd_val;
    logic [2:0] v_exp [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    logic [2:0] p_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [7:0] modes [4] = '{8'h46, 8'h4B, 8'h00, 8'h47};
    logic [5:0] n_vals [3] = '{6'h01, 6'h3F, 6'h00};

    cppcr_config_regs u_dut (
        .clock(clock), .rst(rst), .sclk(sclk), .scs_n(scs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .pll_enable(pll_enable), .timestamp_input(timestamp_input),
        .operating_mode_code(operating_mode_code), .low_power_mode(low_power_mode),
        .high_perf_mode(high_perf_mode), .mode_code_reserved(mode_code_reserved),
        .timestamp_receiver_enable(timestamp_receiver_enable),
        .timestamp_pecl_mode(timestamp_pecl_mode), .timestamp_received(timestamp_received),
        .reference_clock_output(reference_clock_output), .div_v_ratio(div_v_ratio),
        .div_p_ratio(div_p_ratio), .div_n_ratio(div_n_ratio),
        .div_code_reserved(div_code_reserved)
    );

    always #50 clock = ~clock;

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // Each serial phase is held four clocks, above the three-clock minimum
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
        logic [23:0] bits;
        bits  = {rd, addr, wdata};
        rdata = 8'h00;
        scs_n = 1'b0;
        tick(2);
        for (int k = 0; k < 24; k++) begin
            sclk = 1'b0;
            sdi  = bits[23-k];
            tick(4);
            if (rd && k >= 16) begin
                `CHK(sdo_oe, 1'b1)
                rdata = {rdata[6:0], sdo};
            end
            sclk = 1'b1;
            tick(4);
        end
        sclk = 1'b0;
        tick(4);
        scs_n = 1'b1;
        tick(4);
        `CHK(sdo_oe, 1'b0)
    endtask : frame

    task automatic wr_reg(input logic [14:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        frame(1'b0, addr, data, unused);
    endtask : wr_reg

    task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        frame(1'b1, addr, 8'h00, got);
        `CHK(got, exp)
    endtask : rd_chk

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        conclude();
    end

    initial begin
        clock           = 1'b0;
        rst             = 1'b1;
        sclk            = 1'b0;
        scs_n           = 1'b1;
        sdi             = 1'b0;
        pll_enable      = 1'b0;
        timestamp_input = 1'b0;
        fail_count      = 0;
        checked         = 0;
        tick(2);
        rst = 1'b0;
        tick(1);
        // Reset state
        `CHK(high_perf_mode, 1'b1)
        `CHK({div_v_ratio, div_p_ratio}, {3'h5, 3'h1})
        `CHK(div_n_ratio, 6'h20)
        `CHK(reference_clock_output, 1'b0)
        rd_chk(OFS_MODE_SEL_1, RST_MODE_SEL_1);
        rd_chk(OFS_TS_CTRL, RST_TS_CTRL);
        rd_chk(OFS_REFO_CTRL, RST_REFO_CTRL);
        rd_chk(OFS_DIV_A, RST_DIV_A);
        rd_chk(OFS_DIV_B, RST_DIV_B);
        // Reference output comes up with the PLL and no write
        pll_enable = 1'b1;
        tick(2);
        `CHK(reference_clock_output, 1'b1)
        wr_reg(OFS_REFO_CTRL, 8'h00);
        `CHK(reference_clock_output, 1'b0)
        wr_reg(OFS_REFO_CTRL, 8'h01);
        `CHK(reference_clock_output, 1'b1)
        pll_enable = 1'b0;
        tick(2);
        `CHK(reference_clock_output, 1'b0)
        // Low-power code assumes a rate of 1 GSPS or less
        // Companion mode registers are written off-block
        // Recalibration after each mode change is off-block
        // Calibration and link enables sit outside this block, assumed clear
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_MODE_SEL_1, modes[i]);
            `CHK(operating_mode_code, modes[i])
            `CHK(low_power_mode, modes[i] == 8'h46)
            `CHK(high_perf_mode, modes[i] == 8'h4B)
            `CHK(mode_code_reserved, i > 1)
            rd_chk(OFS_MODE_SEL_1, modes[i]);
        end
        wr_reg(OFS_MODE_SEL_1, MODE_HIGH_PERF);
        // Timestamp input gated by its enable
        timestamp_input = 1'b1;
        tick(2);
        `CHK(timestamp_received, 1'b0)
        wr_reg(OFS_TS_CTRL, 8'h03);
        `CHK(timestamp_received, 1'b1)
        timestamp_input = 1'b0;
        tick(2);
        `CHK(timestamp_received, 1'b0)
        wr_reg(OFS_TS_CTRL, 8'h02);
        `CHK({timestamp_pecl_mode, timestamp_receiver_enable}, 2'h2)
        rd_chk(OFS_TS_CTRL, 8'h02);
        wr_reg(OFS_TS_CTRL, 8'h00);
        // Divider codes; PLL reset is held by the host outside this block
        for (int p = 0; p < 4; p++) begin
            for (int v = 0; v < 4; v++) begin
                wr_reg(OFS_DIV_A, {4'h0, p[1:0], v[1:0]});
                `CHK(div_v_ratio, v_exp[v])
                `CHK(div_p_ratio, p_exp[p])
                `CHK(div_code_reserved, (v == 3) || (p == 3))
            end
        end
        rd_chk(OFS_DIV_A, 8'h0F);
        wr_reg(OFS_DIV_A, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_reg(OFS_DIV_B, {2'h0, n_vals[i]});
            `CHK(div_n_ratio, n_vals[i])
            `CHK(div_code_reserved, i == 2)
            rd_chk(OFS_DIV_B, {2'h0, n_vals[i]});
        end
        // Unmapped place is ignored and reads zero
        wr_reg(15'h0040, 8'hA5);
        rd_chk(15'h0040, 8'h00);
        rd_chk(OFS_REFO_CTRL, 8'h01);
        // Mid-run reset brings back every reset value
        wr_reg(OFS_REFO_CTRL, 8'h00);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        `CHK(div_n_ratio, 6'h20)
        `CHK(div_code_reserved, 1'b0)
        rd_chk(OFS_DIV_B, RST_DIV_B);
        rd_chk(OFS_REFO_CTRL, RST_REFO_CTRL);
        pll_enable = 1'b1;
        tick(2);
        `CHK(reference_clock_output, 1'b1)
        conclude();
    end
endmodule : testbench
